//--- logic/dash_shifter.sv
// shifter datapath of the dsp coprocessor: accumulators, wide accumulators and their flags
// assumes a decoder on the same clock issuing one instruction per cycle and a register port master
//
// Notes on behaviour
// - the one-place left shift moves the selected 24-bit accumulator left by one and writes it back.
// - single-place accumulator shifts set carry to the bit shifted out.
// - the eight-place left shift sets carry to the last bit shifted out.
// - every accumulator shift sets zero exactly when the stored result is all zeros.
// - every accumulator shift sets overflow exactly when the operation overflows.
// - negative is overflow exclusive-or the top bit of the shifted result.
// - conditional forms run only with the conditional flag set and otherwise change nothing.
// - the wide left shift moves the selected 52-bit accumulator left by one and writes it back.
// - after a wide shift its guard overflow flag shows whether the result spills into the guard bits.
// - the sticky guard overflow flag is set when a wide shift overflows the guard bits, else it holds.
// - the guard overflow flag updated is the one of the addressed wide accumulator.
// - the eight-place left shift moves the selected accumulator left by eight and writes it back.
// - the left shift through carry loads the previous carry into the lowest result bit.
// - the arithmetic right shift moves the selected accumulator right by one and writes it back.
`include "dash_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module dash_shifter #(
   parameter int GUARD_W = `DASH_GUARD_W
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_op_valid,
   input wire dash_pkg::dash_op_t i_op,
   input wire logic [1:0] i_acc_sel,
   input wire logic i_ma_sel,
   input wire logic i_cond_flag,
   input wire logic [`DASH_ADDR_W-1:0] i_reg_addr,
   input wire logic [`DASH_DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [`DASH_DATA_W-1:0] o_reg_rdata,
   output logic o_carry,
   output logic o_zero,
   output logic o_overflow,
   output logic o_negative,
   output logic o_guard_overflow_flag_zero,
   output logic o_guard_overflow_flag_one,
   output logic o_sticky_guard_overflow,
   output logic o_op_done,
   output logic o_op_skipped
);
   import dash_pkg::*;

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   generate
      if (GUARD_W < 1 || GUARD_W > `DASH_MA_W - 2) begin : g_bad_guard
         $error("guard width out of range");
      end
   endgenerate

   localparam int HEAD_W = GUARD_W + 1;
   localparam int PAD_W = `DASH_MA_W - `DASH_ACC_W;

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------

   // conditional forms of the accumulator shifts
   function automatic logic is_cond(input dash_op_t op);
      case (op)
         OP_COND_SHIFT_LEFT_ONE_ACC,
         OP_COND_SHIFT_LEFT_EIGHT_ACC,
         OP_COND_SHIFT_LEFT_THROUGH_CARRY,
         OP_COND_ARITH_SHIFT_RIGHT_ONE_ACC: begin
            is_cond = 1'b1;
         end
         default: begin
            is_cond = 1'b0;
         end
      endcase
   endfunction : is_cond

   // high when the top n bits of v are not all equal
   function automatic logic head_mixed(input logic [`DASH_MA_W-1:0] v, input int n);
      logic ones;
      logic zeros;

      ones = 1'b1;
      zeros = 1'b1;
      for (int k = 0; k < `DASH_MA_W; k++) begin
         if (k >= `DASH_MA_W - n) begin
            ones = ones & v[k];
            zeros = zeros & ~v[k];
         end
      end
      head_mixed = ~(ones | zeros);
   endfunction : head_mixed

   // one 24-bit shift with its carry and overflow
   function automatic dash_shres_t acc_shift(input dash_op_t op, input logic [`DASH_ACC_W-1:0] a,
                                             input logic c);
      dash_shres_t r;

      r = '0;
      case (op)
         // one place left
         OP_SHIFT_LEFT_ONE_ACC, OP_COND_SHIFT_LEFT_ONE_ACC: begin
            r.value = {a[`DASH_ACC_W-2:0], 1'b0};
            r.carry = a[`DASH_ACC_W-1];
            r.ovf = a[`DASH_ACC_W-1] ^ a[`DASH_ACC_W-2];
         end

         // one place left, old carry into the lowest bit
         OP_SHIFT_LEFT_THROUGH_CARRY, OP_COND_SHIFT_LEFT_THROUGH_CARRY: begin
            r.value = {a[`DASH_ACC_W-2:0], c};
            r.carry = a[`DASH_ACC_W-1];
            r.ovf = a[`DASH_ACC_W-1] ^ a[`DASH_ACC_W-2];
         end

         // eight places left, overflow when the top nine bits disagree
         OP_SHIFT_LEFT_EIGHT_ACC, OP_COND_SHIFT_LEFT_EIGHT_ACC: begin
            r.value = {a[`DASH_ACC_W-1-`DASH_BIG_SHIFT:0], {`DASH_BIG_SHIFT{1'b0}}};
            r.carry = a[`DASH_ACC_W-`DASH_BIG_SHIFT];
            r.ovf = head_mixed({a, {PAD_W{1'b0}}}, `DASH_BIG_SHIFT + 1);
         end

         // one place right, sign kept, cannot overflow
         OP_ARITH_SHIFT_RIGHT_ONE_ACC, OP_COND_ARITH_SHIFT_RIGHT_ONE_ACC: begin
            r.value = {a[`DASH_ACC_W-1], a[`DASH_ACC_W-1:1]};
            r.carry = a[0];
            r.ovf = 1'b0;
         end

         // not an accumulator shift
         default: begin
            r.value = a;
            r.carry = c;
            r.ovf = 1'b0;
         end
      endcase
      acc_shift = r;
   endfunction : acc_shift

   // register port read decode
   function automatic logic [`DASH_DATA_W-1:0] read_word(input dash_state_t s,
                                                         input logic [`DASH_ADDR_W-1:0] addr);
      logic [`DASH_DATA_W-1:0] w;

      w = '0;
      case (addr)
         `DASH_REG_ACC0, `DASH_REG_ACC1, `DASH_REG_ACC2, `DASH_REG_ACC3: begin
            w[`DASH_ACC_W-1:0] = s.acc[addr[1:0]];
         end

         `DASH_REG_MA0_LO: begin
            w = s.ma[0][`DASH_DATA_W-1:0];
         end

         `DASH_REG_MA0_HI: begin
            w[`DASH_MA_HI_W-1:0] = s.ma[0][`DASH_MA_W-1:`DASH_DATA_W];
         end

         `DASH_REG_MA1_LO: begin
            w = s.ma[1][`DASH_DATA_W-1:0];
         end

         `DASH_REG_MA1_HI: begin
            w[`DASH_MA_HI_W-1:0] = s.ma[1][`DASH_MA_W-1:`DASH_DATA_W];
         end

         `DASH_REG_FLAGS: begin
            w[`DASH_FLD_CARRY] = s.carry;
            w[`DASH_FLD_ZERO] = s.zero;
            w[`DASH_FLD_OVF] = s.ovf;
            w[`DASH_FLD_NEG] = s.neg;
            w[`DASH_FLD_GOVF0] = s.guard_ovf[0];
            w[`DASH_FLD_GOVF1] = s.guard_ovf[1];
            w[`DASH_FLD_STICKY] = s.sticky;
         end

         default: begin
            w = '0;
         end
      endcase
      read_word = w;
   endfunction : read_word

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   // registered state and its next value
   dash_state_t st;
   dash_state_t next_st;
   // combinational shift results
   dash_shres_t res;
   logic [`DASH_MA_W-1:0] ma_old;
   logic [`DASH_MA_W-1:0] ma_new;

   always_comb begin
      // ----------------------------------------------------------------
      // defaults
      // ----------------------------------------------------------------
      next_st = st;
      next_st.done = 1'b0;
      next_st.skipped = 1'b0;
      next_st.rd_data = '0;
      res = acc_shift(i_op, st.acc[i_acc_sel], st.carry);
      ma_old = st.ma[i_ma_sel];
      ma_new = {ma_old[`DASH_MA_W-2:0], 1'b0};

      // ----------------------------------------------------------------
      // register port read
      // ----------------------------------------------------------------
      // read sees the state before this cycle's instruction
      if (i_reg_rd) begin
         next_st.rd_data = read_word(st, i_reg_addr);
      end

      // ----------------------------------------------------------------
      // register port write
      // ----------------------------------------------------------------
      if (i_reg_wr) begin
         case (i_reg_addr)
            `DASH_REG_ACC0, `DASH_REG_ACC1, `DASH_REG_ACC2, `DASH_REG_ACC3: begin
               next_st.acc[i_reg_addr[1:0]] = i_reg_wdata[`DASH_ACC_W-1:0];
            end

            `DASH_REG_MA0_LO: begin
               next_st.ma[0][`DASH_DATA_W-1:0] = i_reg_wdata;
            end

            `DASH_REG_MA0_HI: begin
               next_st.ma[0][`DASH_MA_W-1:`DASH_DATA_W] = i_reg_wdata[`DASH_MA_HI_W-1:0];
            end

            `DASH_REG_MA1_LO: begin
               next_st.ma[1][`DASH_DATA_W-1:0] = i_reg_wdata;
            end

            `DASH_REG_MA1_HI: begin
               next_st.ma[1][`DASH_MA_W-1:`DASH_DATA_W] = i_reg_wdata[`DASH_MA_HI_W-1:0];
            end

            `DASH_REG_FLAGS: begin
               next_st.carry = i_reg_wdata[`DASH_FLD_CARRY];
               next_st.zero = i_reg_wdata[`DASH_FLD_ZERO];
               next_st.ovf = i_reg_wdata[`DASH_FLD_OVF];
               next_st.neg = i_reg_wdata[`DASH_FLD_NEG];
               next_st.guard_ovf[0] = i_reg_wdata[`DASH_FLD_GOVF0];
               next_st.guard_ovf[1] = i_reg_wdata[`DASH_FLD_GOVF1];
               // sticky bit clears on a written one
               if (i_reg_wdata[`DASH_FLD_STICKY]) begin
                  next_st.sticky = 1'b0;
               end
            end

            default: begin
            end
         endcase
      end

      // ----------------------------------------------------------------
      // instruction issue
      // ----------------------------------------------------------------
      // overrides a register write of the same cycle; a set of sticky beats its clear
      if (i_op_valid) begin
         // conditional form with the flag low
         if (is_cond(i_op) && !i_cond_flag) begin
            next_st.skipped = 1'b1;
         end else if (i_op == OP_SHIFT_LEFT_ONE_WIDE) begin
            // wide accumulator shift, leaves carry, zero, overflow and negative alone
            next_st.done = 1'b1;
            next_st.ma[i_ma_sel] = ma_new;
            next_st.guard_ovf[i_ma_sel] = head_mixed(ma_new, HEAD_W);
            if (ma_old[`DASH_MA_W-1] ^ ma_old[`DASH_MA_W-2]) begin
               next_st.sticky = 1'b1;
            end
         end else begin
            // accumulator shift
            next_st.done = 1'b1;
            next_st.acc[i_acc_sel] = res.value;
            next_st.carry = res.carry;
            next_st.zero = ~(|res.value);
            next_st.ovf = res.ovf;
            next_st.neg = res.ovf ^ res.value[`DASH_ACC_W-1];
         end
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         // accumulators
         for (int i = 0; i < `DASH_NUM_ACC; i++) begin
            st.acc[i] <= `DASH_RST_ACC;
         end

         // wide accumulators and their guard flags
         for (int j = 0; j < `DASH_NUM_MA; j++) begin
            st.ma[j] <= `DASH_RST_MA;
            st.guard_ovf[j] <= `DASH_RST_FLAG;
         end

         // flags
         st.carry <= `DASH_RST_FLAG;
         st.zero <= `DASH_RST_FLAG;
         st.ovf <= `DASH_RST_FLAG;
         st.neg <= `DASH_RST_FLAG;
         st.sticky <= `DASH_RST_FLAG;

         // port and status
         st.rd_data <= `DASH_RST_DATA;
         st.done <= 1'b0;
         st.skipped <= 1'b0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // register port
   assign o_reg_rdata = st.rd_data;

   // flags
   assign o_carry = st.carry;
   assign o_zero = st.zero;
   assign o_overflow = st.ovf;
   assign o_negative = st.neg;
   assign o_guard_overflow_flag_zero = st.guard_ovf[0];
   assign o_guard_overflow_flag_one = st.guard_ovf[1];
   assign o_sticky_guard_overflow = st.sticky;

   // instruction status
   assign o_op_done = st.done;
   assign o_op_skipped = st.skipped;

endmodule : dash_shifter

`default_nettype wire

//--- shared/dash_cfg.svh
// constants of the accumulator shifter: widths, register offsets, field positions, reset values
// assumes inclusion by bare name from the package and the shifter module
`ifndef DASH_CFG_SVH
`define DASH_CFG_SVH

// ----------------------------------------------------------------
// datapath widths
// ----------------------------------------------------------------
`define DASH_ACC_W 24
`define DASH_NUM_ACC 4
`define DASH_MA_W 52
`define DASH_NUM_MA 2
`define DASH_GUARD_W 4
`define DASH_BIG_SHIFT 8
`define DASH_DATA_W 32
`define DASH_ADDR_W 4
`define DASH_MA_HI_W 20

// ----------------------------------------------------------------
// register offsets (word index on the register port)
// ----------------------------------------------------------------
`define DASH_REG_ACC0 4'h0
`define DASH_REG_ACC1 4'h1
`define DASH_REG_ACC2 4'h2
`define DASH_REG_ACC3 4'h3
`define DASH_REG_MA0_LO 4'h4
`define DASH_REG_MA0_HI 4'h5
`define DASH_REG_MA1_LO 4'h6
`define DASH_REG_MA1_HI 4'h7
`define DASH_REG_FLAGS 4'h8

// ----------------------------------------------------------------
// flag register field positions
// ----------------------------------------------------------------
`define DASH_FLD_CARRY 0
`define DASH_FLD_ZERO 1
`define DASH_FLD_OVF 2
`define DASH_FLD_NEG 3
`define DASH_FLD_GOVF0 4
`define DASH_FLD_GOVF1 5
`define DASH_FLD_STICKY 6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DASH_RST_ACC 24'h000000
`define DASH_RST_MA 52'h0000000000000
`define DASH_RST_FLAG 1'h0
`define DASH_RST_DATA 32'h00000000

`endif

//--- shared/dash_pkg.sv
// types of the accumulator shifter: instruction codes and the module state record
// assumes dash_cfg.svh on the include path
`include "dash_cfg.svh"

package dash_pkg;

   // ----------------------------------------------------------------
   // shift instructions
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_SHIFT_LEFT_ONE_ACC,
      OP_COND_SHIFT_LEFT_ONE_ACC,
      OP_SHIFT_LEFT_EIGHT_ACC,
      OP_COND_SHIFT_LEFT_EIGHT_ACC,
      OP_SHIFT_LEFT_THROUGH_CARRY,
      OP_COND_SHIFT_LEFT_THROUGH_CARRY,
      OP_ARITH_SHIFT_RIGHT_ONE_ACC,
      OP_COND_ARITH_SHIFT_RIGHT_ONE_ACC,
      OP_SHIFT_LEFT_ONE_WIDE
   } dash_op_t;

   // ----------------------------------------------------------------
   // result of one 24-bit accumulator shift
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`DASH_ACC_W-1:0] value;
      logic carry;
      logic ovf;
   } dash_shres_t;

   // ----------------------------------------------------------------
   // whole state of the shifter
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [`DASH_NUM_ACC-1:0][`DASH_ACC_W-1:0] acc;
      logic [`DASH_NUM_MA-1:0][`DASH_MA_W-1:0] ma;
      logic carry;
      logic zero;
      logic ovf;
      logic neg;
      logic [`DASH_NUM_MA-1:0] guard_ovf;
      logic sticky;
      logic [`DASH_DATA_W-1:0] rd_data;
      logic done;
      logic skipped;
   } dash_state_t;

endpackage : dash_pkg

//--- tb/dash_dec_model.sv
// decoder model: turns one-cycle bench requests into registered instruction issues
// assumes the bench raises a request for one cycle per instruction on the same clock
`timescale 1ns/1ps
`default_nettype none
module dash_dec_model
   import dash_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_req,
   input wire dash_pkg::dash_op_t i_req_op,
   input wire logic [1:0] i_req_acc,
   input wire logic i_req_ma,
   input wire logic i_req_cond,
   output logic o_op_valid,
   output dash_pkg::dash_op_t o_op,
   output logic [1:0] o_acc_sel,
   output logic o_ma_sel,
   output logic o_cond_flag
);
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_op_valid <= 1'b0;
         o_op <= OP_SHIFT_LEFT_ONE_ACC;
         o_acc_sel <= 2'h0;
         o_ma_sel <= 1'b0;
         o_cond_flag <= 1'b0;
      end else if (i_req) begin
         o_op_valid <= 1'b1;
         o_op <= i_req_op;
         o_acc_sel <= i_req_acc;
         o_ma_sel <= i_req_ma;
         o_cond_flag <= i_req_cond;
      end else begin
         // idle select and condition fields keep moving, the op holds, so off-issue sampling shows up
         o_op_valid <= 1'b0;
         o_acc_sel <= ~o_acc_sel;
         o_ma_sel <= ~o_ma_sel;
         o_cond_flag <= ~o_cond_flag;
      end
   end
endmodule : dash_dec_model
`default_nettype wire

//--- tb/dash_shifter_chk.sv
// port checker of the accumulator shifter
// assumes binding to dash_shifter; sees its ports only
`include "dash_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dash_shifter_chk
   import dash_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic i_op_valid,
   input wire dash_pkg::dash_op_t i_op,
   input wire logic [1:0] i_acc_sel,
   input wire logic i_ma_sel,
   input wire logic i_cond_flag,
   input wire logic [`DASH_ADDR_W-1:0] i_reg_addr,
   input wire logic [`DASH_DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [`DASH_DATA_W-1:0] o_reg_rdata,
   input wire logic o_carry,
   input wire logic o_zero,
   input wire logic o_overflow,
   input wire logic o_negative,
   input wire logic o_guard_overflow_flag_zero,
   input wire logic o_guard_overflow_flag_one,
   input wire logic o_sticky_guard_overflow,
   input wire logic o_op_done,
   input wire logic o_op_skipped
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic fw = i_reg_wr && i_reg_addr == `DASH_REG_FLAGS;
   wire logic wide = i_op_valid && i_op == OP_SHIFT_LEFT_ONE_WIDE;
   a_run_gives_done: assert property (i_op_valid && (!i_op[0] || i_cond_flag) |=> o_op_done && !o_op_skipped)
      else $error("executed op without done");
   a_skip_keeps_flags: assert property (i_op_valid && i_op[0] && !wide && !i_cond_flag && !fw |=>
      o_op_skipped && $stable({o_carry, o_zero, o_overflow, o_negative})) else $error("skipped op moved flags");
   a_wide_keeps_czvn: assert property (wide && !fw |=> $stable({o_carry, o_zero, o_overflow, o_negative}))
      else $error("wide shift moved flags");
   a_guard_sel_zero: assert property (wide && !i_ma_sel && !fw |=> $stable(o_guard_overflow_flag_one))
      else $error("wrong guard flag moved");
   a_guard_sel_one: assert property (wide && i_ma_sel && !fw |=> $stable(o_guard_overflow_flag_zero))
      else $error("wrong guard flag moved");
   a_sar_no_ovf: assert property (i_op_valid && i_op[3:1] == 3'h3 && (!i_op[0] || i_cond_flag) |=> !o_overflow)
      else $error("right shift overflowed");
   a_sticky_from_wide: assert property ($rose(o_sticky_guard_overflow) |-> $past(wide))
      else $error("sticky set without wide shift");
   a_sticky_no_fall: assert property ($fell(o_sticky_guard_overflow) |-> $past(fw && i_reg_wdata[6]))
      else $error("sticky dropped by itself");
   a_zero_neg_ovf: assert property (o_op_done && o_zero && $past(!wide) |-> o_negative == o_overflow)
      else $error("negative wrong on zero result");
endmodule : dash_shifter_chk
bind dash_shifter dash_shifter_chk chk_u (.*);
`default_nettype wire

//--- tb/dash_shifter_tb.sv
// testbench of the accumulator shifter: register tasks, a table of shift cases, wide shifts
// assumes the decoder model issues the instructions and the checker is bound
`include "dash_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module dash_shifter_tb import dash_pkg::*;;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic req = 1'b0, req_ma = 1'b0, req_cond = 1'b0, i_reg_wr = 1'b0, i_reg_rd = 1'b0;
   dash_op_t req_op = OP_SHIFT_LEFT_ONE_ACC;
   logic [1:0] req_acc = 2'h0;
   logic [3:0] i_reg_addr = 4'h0;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_op_valid, i_ma_sel, i_cond_flag, o_op_done, o_op_skipped, o_carry, o_zero, o_overflow, o_negative;
   logic o_guard_overflow_flag_zero, o_guard_overflow_flag_one, o_sticky_guard_overflow;
   dash_op_t i_op;
   logic [1:0] i_acc_sel;
   logic [31:0] o_reg_rdata;
   int n_fail = 0, n_tests = 0;
   logic [23:0] vals [8] = '{24'h400000, 24'h800001, 24'h00ff80, 24'h0, 24'h0, 24'h7fffff, 24'h800001, 24'h1};
   always #2.5 i_clk = ~i_clk;
   dash_dec_model dec_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req), .i_req_op(req_op),
      .i_req_acc(req_acc), .i_req_ma(req_ma), .i_req_cond(req_cond), .o_op_valid(i_op_valid),
      .o_op(i_op), .o_acc_sel(i_acc_sel), .o_ma_sel(i_ma_sel), .o_cond_flag(i_cond_flag));
   dash_shifter #(.GUARD_W(4)) dut_u (.*);
   task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_clk);
      i_reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
      @(posedge i_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_clk);
      i_reg_rd <= 1'b0;
      #1 cmp(what, exp, o_reg_rdata);
   endtask : rd
   task automatic issue(input dash_op_t op, input logic [1:0] a, input logic m, input logic c, input logic skip);
      int k;
      @(posedge i_clk);
      req <= 1'b1;
      req_op <= op;
      req_acc <= a;
      req_ma <= m;
      req_cond <= c;
      @(posedge i_clk);
      req <= 1'b0;
      for (k = 0; k < 4 && o_op_done !== 1'b1 && o_op_skipped !== 1'b1; k++) @(posedge i_clk) #1;
      cmp("skipped", {31'h0, skip}, {31'h0, o_op_skipped});
      cmp("done", {31'h0, !skip}, {31'h0, o_op_done});
   endtask : issue
   function automatic logic [25:0] ref_op(input logic [3:0] op, input logic [23:0] a, input logic c);
      case (op[3:1])
         3'h0: return {a[22:0], 1'b0, a[23], a[23] ^ a[22]};
         3'h1: return {a[15:0], 8'h0, a[16], !(a[23:15] == 9'h0 || a[23:15] == 9'h1ff)};
         3'h2: return {a[22:0], c, a[23], a[23] ^ a[22]};
         default: return {a[23], a[23:1], a[0], 1'b0};
      endcase
   endfunction : ref_op
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   initial begin
      #20000;
      n_fail++;
      final_report();
   end
   initial begin
      int i, o;
      logic [25:0] r;
      logic [31:0] f;
      repeat (6) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      rd(`DASH_REG_FLAGS, 32'h0, "flags at reset");
      rd(`DASH_REG_ACC0, 32'h0, "acc at reset");
      for (i = 0; i < 12; i++) begin
         o = (i < 8) ? i : 2 * i - 15;
         wr({2'h0, 2'(i)}, {8'h0, vals[o]});
         wr(`DASH_REG_FLAGS, 32'h1);
         issue(dash_op_t'(o), 2'(i), 1'b0, i < 8, i >= 8);
         r = ref_op(4'(o), vals[o], 1'b1);
         f = (i < 8) ? {28'h0, r[0] ^ r[25], r[0], r[25:2] == 24'h0, r[1]} : 32'h1;
         cmp("flag pins", f, {25'h0, o_sticky_guard_overflow, o_guard_overflow_flag_one, o_guard_overflow_flag_zero,
            o_negative, o_overflow, o_zero, o_carry});
         rd({2'h0, 2'(i)}, {8'h0, (i < 8) ? r[25:2] : vals[o]}, "accumulator");
         rd(`DASH_REG_FLAGS, f, "flags");
         $display("shift case %0d done", i);
      end
      wr(`DASH_REG_FLAGS, 32'h20);
      wr(`DASH_REG_MA0_LO, 32'h0);
      wr(`DASH_REG_MA0_HI, 32'h40000);
      wr(`DASH_REG_MA1_LO, 32'h80000000);
      wr(`DASH_REG_MA1_HI, 32'h0);
      issue(OP_SHIFT_LEFT_ONE_WIDE, 2'h0, 1'b0, 1'b0, 1'b0);
      issue(OP_SHIFT_LEFT_ONE_WIDE, 2'h0, 1'b1, 1'b0, 1'b0);
      cmp("wide flag pins", 32'h50, {25'h0, o_sticky_guard_overflow, o_guard_overflow_flag_one,
         o_guard_overflow_flag_zero, o_negative, o_overflow, o_zero, o_carry});
      rd(`DASH_REG_MA0_HI, 32'h80000, "wide 0 high");
      rd(`DASH_REG_MA0_LO, 32'h0, "wide 0 low");
      rd(`DASH_REG_MA1_LO, 32'h0, "wide 1 low");
      rd(`DASH_REG_MA1_HI, 32'h1, "wide 1 high");
      rd(`DASH_REG_FLAGS, 32'h50, "wide flags");
      wr(`DASH_REG_FLAGS, 32'h40);
      rd(`DASH_REG_FLAGS, 32'h0, "sticky cleared");
      rd(4'h9, 32'h0, "unmapped");
      $display("wide shift case done");
      final_report();
   end
endmodule : dash_shifter_tb
`default_nettype wire
